// *** rtl/fap_pkg.sv ***
// shared constants and arithmetic helpers for the fm audio post-processing chain
package fap_pkg;
	// clock rate and hi-cut ramp timing
	localparam int CLK_HZ = 40_000_000;
	localparam int HC_MIN_RAMP_MS = 2;
	localparam int HC_RAMP_STEPS = 256;
	// cycles per hi-cut level step at the fastest rate (rounded down)
	localparam int HC_TICK_CYC = CLK_HZ / 1000 * HC_MIN_RAMP_MS / HC_RAMP_STEPS;
	localparam logic [8:0] HC_TICK_LAST = 9'(HC_TICK_CYC - 1);
	// rate code 15 gives 2 ms * 2^15, about 64 s
	localparam logic [3:0] HC_RATE_MAX = 4'hF;

	// level scale: 0 = none, 256 = full
	localparam logic [8:0] LVL_FULL = 9'h100;
	localparam logic [8:0] LVL_ZERO = 9'h000;
	localparam logic [8:0] BLEND_RST = 9'h000;
	localparam logic [8:0] GAIN_RST = 9'h100;
	localparam logic [8:0] HC_RST = 9'h000;
	localparam int NMET = 3;
	localparam int MET_RSSI = 0;
	localparam int MET_SNR = 1;
	localparam int MET_MP = 2;
	localparam int PIPE_LAT = 4;

	// filter fixed point: coefficient q15, accumulator 8 extra fraction bits
	localparam int COEF_FRAC = 15;
	localparam int ACC_FRAC = 8;
	// one-pole coefficients at a 192 kHz sample rate
	localparam logic [15:0] COEF_BAND15K = 16'h31AA;
	localparam logic [15:0] COEF_DEEMPH50 = 16'h0CA9;
	localparam logic [15:0] COEF_DEEMPH75 = 16'h0896;
	localparam logic [2:0] HC_SEL_OFF = 3'h0;

	// hi-cut corner per setting: 2, 3, 4, 6, 8, 10, 11 kHz
	function automatic logic [15:0] hc_coef(input logic [2:0] sel);
		case (sel)
			3'h1: hc_coef = 16'h0819;
			3'h2: hc_coef = 16'h0BFC;
			3'h3: hc_coef = 16'h0FB6;
			3'h4: hc_coef = 16'h16CB;
			3'h5: hc_coef = 16'h1D6A;
			3'h6: hc_coef = 16'h23AA;
			3'h7: hc_coef = 16'h26AE;
			default: hc_coef = COEF_BAND15K;
		endcase
	endfunction : hc_coef

	// clip a 17-bit value into 16 bits
	function automatic logic signed [15:0] sat16(input logic signed [16:0] x);
		if (x > 17'sh07FFF) sat16 = 16'sh7FFF;
		else if (x < 17'sh18000) sat16 = 16'sh8000;
		else sat16 = x[15:0];
	endfunction : sat16

	// level 0..256 from q in lo..hi, clamped at the ends
	function automatic logic [8:0] lvl_tgt(input logic [7:0] q, lo, hi);
		logic [15:0] num;
		logic [7:0] den;
		num = {8'(q - lo), 8'h00};
		den = hi - lo;
		if (q <= lo) lvl_tgt = LVL_ZERO;
		else if (q >= hi) lvl_tgt = LVL_FULL;
		else lvl_tgt = 9'(num / {8'h00, den});
	endfunction : lvl_tgt

	// move cur toward tgt by at most dn (falling) or up (rising)
	function automatic logic [8:0] ramp(input logic [8:0] cur, tgt, input logic [7:0] dn, up);
		if (tgt < cur) ramp = (10'(cur - tgt) <= 10'(dn)) ? tgt : 9'(10'(cur) - 10'(dn));
		else ramp = (10'(tgt - cur) <= 10'(up)) ? tgt : 9'(10'(cur) + 10'(up));
	endfunction : ramp

	// x * k / 256
	function automatic logic signed [15:0] scale(input logic signed [15:0] x, input logic [8:0] k);
		logic signed [25:0] p;
		p = x * $signed({1'b0, k});
		scale = sat16(p[24:8]);
	endfunction : scale

	// cross-fade from x toward y by k / 256
	function automatic logic signed [15:0] xfade(input logic signed [15:0] x, y,
			input logic [8:0] k);
		logic signed [26:0] p;
		p = (17'(y) - 17'(x)) * $signed({1'b0, k});
		xfade = sat16(17'(x) + p[24:8]);
	endfunction : xfade
endpackage : fap_pkg

// *** rtl/fap_lpf.sv ***
// one-pole low-pass section with a run-time coefficient
`timescale 1ns/100ps
`default_nettype none
module fap_lpf (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_en,
	input wire logic signed [15:0] i_x,
	input wire logic [15:0] i_coef,
	output logic signed [15:0] o_next
);
	typedef struct packed {
		logic signed [23:0] acc;
	} fap_lpf_s;

	fap_lpf_s st_q;
	fap_lpf_s st_d;
	logic signed [24:0] err;
	logic signed [41:0] prod;
	logic signed [23:0] acc_nx;

	// accumulate a fraction of the error; o_next is the updated output
	always_comb begin
		err = 25'($signed({i_x, 8'h00})) - 25'(st_q.acc);
		prod = err * $signed({1'b0, i_coef});
		acc_nx = st_q.acc + prod[fap_pkg::COEF_FRAC + 23:fap_pkg::COEF_FRAC];
		o_next = acc_nx[fap_pkg::ACC_FRAC + 15:fap_pkg::ACC_FRAC];
		st_d = st_q;
		if (i_en) begin
			st_d.acc = acc_nx;
		end
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// each update lands between the old output and the input, never beyond it
	a_lpf_track: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_en |-> ((i_x >= $signed(st_q.acc[23:8])) ?
		(o_next >= $signed(st_q.acc[23:8]) && o_next <= i_x) :
		(o_next <= $signed(st_q.acc[23:8]) && o_next >= i_x)))
		else $error("low-pass update overshoots its input");
endmodule : fap_lpf
`default_nettype wire

// *** rtl/fap_audio_post.sv ***
// fm audio post-processing: decode, blend, hi-cut, de-emphasis, soft mute, volume
// Contract
// - pilot tone is the L-R demodulation reference
// - band-limited L+R is the mono output
// - left is sum plus diff, right is sum minus diff
// - poorest of three metrics sets blend
// - any metric below mono threshold gives mono
// - all metrics above stereo threshold give stereo
// - in-between blend proportional, ramped by rates
// - each metric has own thresholds and rates
// - blend state readable as quality status
// - metrics reported to host
// - de-emphasis selectable 50 or 75 us
// - host can mute the audio output
// - volume is a digital gain before converters
// - soft mute triggered only by low snr
// - soft mute depth, attack, decay programmable
// - hi-cut watches snr and multipath thresholds
// - seven selectable hi-cut filter settings
// - shared hi-cut attack and release, 2ms-64s
// - applied hi-cut level reported as status
// - 15 kHz hi-cut setting disables hi-cut
`timescale 1ns/100ps
`default_nettype none
module fap_audio_post (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_MPX_VLD,
	input wire logic signed [15:0] I_MPX,
	input wire logic signed [15:0] I_PILOT,
	input wire logic [7:0] I_RSSI,
	input wire logic [7:0] I_SNR,
	input wire logic [7:0] I_MULTIPATH,
	input wire logic [7:0] I_BL_RSSI_MONO,
	input wire logic [7:0] I_BL_RSSI_STEREO,
	input wire logic [7:0] I_BL_RSSI_ATTACK,
	input wire logic [7:0] I_BL_RSSI_RELEASE,
	input wire logic [7:0] I_BL_SNR_MONO,
	input wire logic [7:0] I_BL_SNR_STEREO,
	input wire logic [7:0] I_BL_SNR_ATTACK,
	input wire logic [7:0] I_BL_SNR_RELEASE,
	input wire logic [7:0] I_BL_MP_MONO,
	input wire logic [7:0] I_BL_MP_STEREO,
	input wire logic [7:0] I_BL_MP_ATTACK,
	input wire logic [7:0] I_BL_MP_RELEASE,
	input wire logic [7:0] I_HC_SNR_MIN,
	input wire logic [7:0] I_HC_SNR_MAX,
	input wire logic [7:0] I_HC_MP_MIN,
	input wire logic [7:0] I_HC_MP_MAX,
	input wire logic [2:0] I_HC_SEL,
	input wire logic [3:0] I_HC_ATTACK,
	input wire logic [3:0] I_HC_RELEASE,
	input wire logic I_DEEMPH_TIME_CONSTANT_PROP,
	input wire logic [7:0] I_SM_SNR_THR,
	input wire logic [7:0] I_SM_DEPTH,
	input wire logic [7:0] I_SM_ATTACK,
	input wire logic [7:0] I_SM_DECAY,
	input wire logic [5:0] I_VOLUME,
	input wire logic I_MUTE,
	output logic signed [15:0] O_LEFT_ANALOG_OUT,
	output logic signed [15:0] O_RIGHT_ANALOG_OUT,
	output logic O_AUDIO_VLD,
	output logic [8:0] O_QSTAT_BLEND,
	output logic [8:0] O_QSTAT_HICUT,
	output logic O_QSTAT_SMUTE,
	output logic [7:0] O_QSTAT_RSSI,
	output logic [7:0] O_QSTAT_SNR,
	output logic [7:0] O_QSTAT_MP
);
	typedef struct packed {
		logic [2:0][8:0] lvl;
		logic [8:0] blend;
		logic signed [15:0] l1;
		logic signed [15:0] r1;
		logic signed [15:0] l2;
		logic signed [15:0] r2;
		logic signed [15:0] l3;
		logic signed [15:0] r3;
		logic signed [15:0] out_l;
		logic signed [15:0] out_r;
		logic [8:0] hc_lvl;
		logic [8:0] hc_tick;
		logic [15:0] hc_div;
		logic [8:0] gain;
		logic smute;
		logic [3:0] vld;
		logic [7:0] rssi;
		logic [7:0] snr;
		logic [7:0] mp;
	} fap_state_s;

	localparam fap_state_s ST_RST = '{gain: fap_pkg::GAIN_RST, blend: fap_pkg::BLEND_RST,
		hc_lvl: fap_pkg::HC_RST, default: '0};

	fap_state_s st_q;
	fap_state_s st_d;
	logic [2:0][7:0] qual;
	logic [2:0][7:0] bl_lo;
	logic [2:0][7:0] bl_hi;
	logic [2:0][7:0] bl_atk;
	logic [2:0][7:0] bl_rel;
	logic [2:0][8:0] bl_tgt;
	logic signed [31:0] psq;
	logic signed [17:0] ref38;
	logic signed [33:0] dmix;
	logic signed [15:0] diff_in;
	logic signed [15:0] sum_nx;
	logic signed [15:0] diff_nx;
	logic signed [15:0] hcl_nx;
	logic signed [15:0] hcr_nx;
	logic signed [15:0] del_nx;
	logic signed [15:0] der_nx;
	logic signed [25:0] bprod;
	logic signed [16:0] db;
	logic [15:0] hc_coef;
	logic [15:0] de_coef;
	logic [8:0] hc_snr_amt;
	logic [8:0] hc_mp_amt;
	logic [8:0] hc_tgt;
	logic [8:0] sm_tgt;
	logic [15:0] hc_per;
	logic hc_tick_hit;
	logic hc_up;
	logic [8:0] vol_k;

	// quality scale per metric: multipath inverted so higher is better
	assign qual = {~I_MULTIPATH, I_SNR, I_RSSI};
	assign bl_lo = {~I_BL_MP_MONO, I_BL_SNR_MONO, I_BL_RSSI_MONO};
	assign bl_hi = {~I_BL_MP_STEREO, I_BL_SNR_STEREO, I_BL_RSSI_STEREO};
	assign bl_atk = {I_BL_MP_ATTACK, I_BL_SNR_ATTACK, I_BL_RSSI_ATTACK};
	assign bl_rel = {I_BL_MP_RELEASE, I_BL_SNR_RELEASE, I_BL_RSSI_RELEASE};

	// doubled pilot cos(2x) = 2cos^2 - 1 as 38 kHz carrier
	assign psq = I_PILOT * I_PILOT;
	assign ref38 = 18'(psq >>> 14) - 18'sh08000;
	assign dmix = I_MPX * ref38;
	assign diff_in = fap_pkg::sat16(dmix[30:14]);

	fap_lpf u_sum (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_en(I_MPX_VLD),
		.i_x(I_MPX),
		.i_coef(fap_pkg::COEF_BAND15K),
		.o_next(sum_nx)
	);

	// band-limited difference channel
	fap_lpf u_diff (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_en(I_MPX_VLD),
		.i_x(diff_in),
		.i_coef(fap_pkg::COEF_BAND15K),
		.o_next(diff_nx)
	);

	// filter corner chosen from seven settings
	assign hc_coef = fap_pkg::hc_coef(I_HC_SEL);

	// hi-cut low-pass, left and right
	fap_lpf u_hc_l (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_en(st_q.vld[0]),
		.i_x(st_q.l1),
		.i_coef(hc_coef),
		.o_next(hcl_nx)
	);
	fap_lpf u_hc_r (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_en(st_q.vld[0]),
		.i_x(st_q.r1),
		.i_coef(hc_coef),
		.o_next(hcr_nx)
	);

	// de-emphasis time constant: 1 = 75 us, 0 = 50 us
	assign de_coef = I_DEEMPH_TIME_CONSTANT_PROP ? fap_pkg::COEF_DEEMPH75 :
		fap_pkg::COEF_DEEMPH50;

	// de-emphasis low-pass, left and right
	fap_lpf u_de_l (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_en(st_q.vld[1]),
		.i_x(st_q.l2),
		.i_coef(de_coef),
		.o_next(del_nx)
	);
	fap_lpf u_de_r (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_en(st_q.vld[1]),
		.i_x(st_q.r2),
		.i_coef(de_coef),
		.o_next(der_nx)
	);

	// hi-cut amounts from snr and multipath windows
	assign hc_snr_amt = fap_pkg::LVL_FULL - fap_pkg::lvl_tgt(I_SNR, I_HC_SNR_MIN, I_HC_SNR_MAX);
	assign hc_mp_amt = fap_pkg::LVL_FULL -
		fap_pkg::lvl_tgt(~I_MULTIPATH, ~I_HC_MP_MAX, ~I_HC_MP_MIN);
	assign hc_tgt = (hc_snr_amt > hc_mp_amt) ? hc_snr_amt : hc_mp_amt;
	assign hc_tick_hit = (st_q.hc_tick == fap_pkg::HC_TICK_LAST);
	assign hc_up = (hc_tgt > st_q.hc_lvl);
	// one shared rate pair, 2 ms * 2^code per full ramp
	assign hc_per = (16'h0001 << (hc_up ? I_HC_ATTACK : I_HC_RELEASE)) - 16'h0001;

	// soft mute target set by snr alone
	assign sm_tgt = (I_SNR < I_SM_SNR_THR) ? fap_pkg::LVL_FULL - {1'b0, I_SM_DEPTH} :
		fap_pkg::LVL_FULL;
	// volume 0..63 maps to gain (v+1)/64
	assign vol_k = {1'b0, 6'(I_VOLUME + 6'h01) == 6'h00 ? 6'h00 : 6'(I_VOLUME + 6'h01), 2'b00} |
		((I_VOLUME == 6'h3F) ? fap_pkg::LVL_FULL : 9'h000);

	// blended difference for the output matrix
	assign bprod = diff_nx * $signed({1'b0, st_q.blend});
	assign db = bprod[24:8];

	// next-state logic for every stage
	always_comb begin
		st_d = st_q;
		// one valid bit per stage, in chain order
		st_d.vld = {st_q.vld[2:0], I_MPX_VLD};
		for (int i = 0; i < fap_pkg::NMET; i++) begin
			bl_tgt[i] = fap_pkg::lvl_tgt(qual[i], bl_lo[i], bl_hi[i]);
		end
		if (I_MPX_VLD) begin
			// ramp each level with its attack and release
			for (int i = 0; i < fap_pkg::NMET; i++) begin
				st_d.lvl[i] = fap_pkg::ramp(st_q.lvl[i], bl_tgt[i], bl_atk[i], bl_rel[i]);
			end
			// stage 0: left = sum + diff, right = sum - diff
			st_d.l1 = fap_pkg::sat16(17'(sum_nx) + db);
			st_d.r1 = fap_pkg::sat16(17'(sum_nx) - db);
			// soft mute gain ramps by attack and decay
			st_d.gain = fap_pkg::ramp(st_q.gain, sm_tgt, I_SM_ATTACK, I_SM_DECAY);
			st_d.smute = (sm_tgt != fap_pkg::LVL_FULL);
			st_d.rssi = I_RSSI;
			st_d.snr = I_SNR;
			st_d.mp = I_MULTIPATH;
		end
		st_d.blend = st_d.lvl[fap_pkg::MET_RSSI];
		if (st_d.lvl[fap_pkg::MET_SNR] < st_d.blend) st_d.blend = st_d.lvl[fap_pkg::MET_SNR];
		if (st_d.lvl[fap_pkg::MET_MP] < st_d.blend) st_d.blend = st_d.lvl[fap_pkg::MET_MP];
		// hi-cut level steps one count per rate period
		st_d.hc_tick = hc_tick_hit ? 9'h000 : st_q.hc_tick + 9'h001;
		if (hc_tick_hit) begin
			if (hc_tgt == st_q.hc_lvl) begin
				st_d.hc_div = 16'h0000;
			end else if (st_q.hc_div >= hc_per) begin
				st_d.hc_div = 16'h0000;
				st_d.hc_lvl = hc_up ? st_q.hc_lvl + 9'h001 : st_q.hc_lvl - 9'h001;
			end else begin
				st_d.hc_div = st_q.hc_div + 16'h0001;
			end
		end
		// stage 1: hi-cut cross-fade
		if (st_q.vld[0]) begin
			// setting 0 is the 15 kHz bandwidth, no hi-cut
			if (I_HC_SEL == fap_pkg::HC_SEL_OFF) begin
				st_d.l2 = st_q.l1;
				st_d.r2 = st_q.r1;
			end else begin
				st_d.l2 = fap_pkg::xfade(st_q.l1, hcl_nx, st_q.hc_lvl);
				st_d.r2 = fap_pkg::xfade(st_q.r1, hcr_nx, st_q.hc_lvl);
			end
		end
		// stage 2: de-emphasis then soft mute gain
		if (st_q.vld[1]) begin
			st_d.l3 = fap_pkg::scale(del_nx, st_q.gain);
			st_d.r3 = fap_pkg::scale(der_nx, st_q.gain);
		end
		// stage 3: volume and host mute
		if (st_q.vld[2]) begin
			st_d.out_l = I_MUTE ? 16'sh0000 : fap_pkg::scale(st_q.l3, vol_k);
			st_d.out_r = I_MUTE ? 16'sh0000 : fap_pkg::scale(st_q.r3, vol_k);
		end
	end

	// state register
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from state
	assign O_LEFT_ANALOG_OUT = st_q.out_l;
	assign O_RIGHT_ANALOG_OUT = st_q.out_r;
	assign O_AUDIO_VLD = st_q.vld[3];
	assign O_QSTAT_BLEND = st_q.blend;
	assign O_QSTAT_HICUT = st_q.hc_lvl;
	assign O_QSTAT_SMUTE = st_q.smute;
	assign O_QSTAT_RSSI = st_q.rssi;
	assign O_QSTAT_SNR = st_q.snr;
	assign O_QSTAT_MP = st_q.mp;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	// checks
	a_mono_equal: assert property (I_MPX_VLD && st_q.blend == fap_pkg::LVL_ZERO |=>
		st_q.l1 == st_q.r1)
		else $error("mono blend left and right differ");
	a_mono_fall: assert property (I_MPX_VLD && bl_tgt[fap_pkg::MET_SNR] == 9'h000 |=>
		st_q.lvl[fap_pkg::MET_SNR] <= $past(st_q.lvl[fap_pkg::MET_SNR]) &&
		O_QSTAT_BLEND <= st_q.lvl[fap_pkg::MET_SNR])
		else $error("blend rose while a metric is below mono");
	a_stereo_rise: assert property (I_MPX_VLD && (&I_BL_RSSI_RELEASE) &&
		(bl_tgt == {3{fap_pkg::LVL_FULL}}) |=> (st_q.lvl[fap_pkg::MET_RSSI] == fap_pkg::LVL_FULL ||
		($past(st_q.lvl[fap_pkg::MET_RSSI]) == fap_pkg::LVL_ZERO &&
		st_q.lvl[fap_pkg::MET_RSSI] == 9'h0FF)))
		else $error("full stereo not reached with maximum release");
	a_blend_min: assert property (st_q.blend <= st_q.lvl[0] && st_q.blend <= st_q.lvl[1]
		&& st_q.blend <= st_q.lvl[2] && (st_q.blend == st_q.lvl[0] || st_q.blend == st_q.lvl[1]
		|| st_q.blend == st_q.lvl[2]))
		else $error("blend is not the poorest metric level");
	a_hicut_off: assert property (st_q.vld[0] && I_HC_SEL == fap_pkg::HC_SEL_OFF |=>
		st_q.l2 == $past(st_q.l1) && st_q.r2 == $past(st_q.r1))
		else $error("hi-cut applied at the 15 kHz setting");
	a_hicut_step: assert property ($changed(O_QSTAT_HICUT) |-> $past(hc_tick_hit) &&
		(O_QSTAT_HICUT == $past(O_QSTAT_HICUT) + 9'h001 ||
		O_QSTAT_HICUT == $past(O_QSTAT_HICUT) - 9'h001))
		else $error("hi-cut level moved off a rate tick");
	a_smute_snr: assert property (I_MPX_VLD && I_SNR >= I_SM_SNR_THR |=>
		st_q.gain >= $past(st_q.gain))
		else $error("soft mute deepened with snr above threshold");
	a_mute_zero: assert property (st_q.vld[2] && I_MUTE |=>
		O_LEFT_ANALOG_OUT == 16'sh0000 && O_RIGHT_ANALOG_OUT == 16'sh0000)
		else $error("output not silent under mute");
	a_vol_unity: assert property (st_q.vld[2] && !I_MUTE && I_VOLUME == 6'h3F |=>
		O_LEFT_ANALOG_OUT == $past(st_q.l3))
		else $error("full volume is not unity gain");
	a_latency: assert property (I_MPX_VLD |-> ##4 O_AUDIO_VLD)
		else $error("audio sample not out after four cycles");
	a_status_snr: assert property (I_MPX_VLD |=> O_QSTAT_SNR == $past(I_SNR))
		else $error("snr status not updated");

	// scenarios
	c_full_mono: cover property (O_QSTAT_BLEND == fap_pkg::LVL_ZERO ##1 O_AUDIO_VLD);
	c_full_stereo: cover property (O_QSTAT_BLEND == fap_pkg::LVL_FULL ##1 O_AUDIO_VLD);
	c_hicut_full: cover property (O_QSTAT_HICUT == fap_pkg::LVL_FULL);
	c_smute: cover property (O_QSTAT_SMUTE && O_AUDIO_VLD);
endmodule : fap_audio_post
`default_nettype wire

// *** tb/fap_demod_model.sv ***
// behavioural fm demodulator that feeds mpx samples to the chain
`timescale 1ns/100ps
`default_nettype none
module fap_demod_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic [3:0] i_gap,
	input wire logic signed [15:0] i_mpx,
	input wire logic signed [15:0] i_pilot,
	output logic o_vld,
	output logic signed [15:0] o_mpx,
	output logic signed [15:0] o_pilot
);
	logic [3:0] gap_q;
	// one strobe every i_gap+1 cycles while running
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_q <= 4'h0;
			o_vld <= 1'b0;
			o_mpx <= 16'sh0000;
			o_pilot <= 16'sh0000;
		end else if (i_run && gap_q == 4'h0) begin
			o_vld <= 1'b1;
			o_mpx <= i_mpx;
			o_pilot <= i_pilot;
			gap_q <= i_gap;
		end else begin
			o_vld <= 1'b0;
			o_mpx <= ~o_mpx; // stale data must never look valid
			o_pilot <= ~o_pilot;
			if (gap_q != 4'h0) gap_q <= gap_q - 4'h1;
		end
	end
endmodule : fap_demod_model
`default_nettype wire

// *** tb/fap_audio_post_tb.sv ***
// self-checking bench for the fm audio post-processing chain
`timescale 1ns/100ps
`default_nettype none
module fap_audio_post_tb;
	logic clk, rst_n, run, vld, de, mute, avld, smute;
	logic [3:0] gap, hat, hrl;
	logic [2:0] hsel;
	logic [5:0] vol;
	logic signed [15:0] mpx, pilot, mpx_o, pil_o, left, right, v0, o50, o75;
	logic [7:0] rssi, snr, mp, hs0, hs1, hm0, hm1, smt, smd, sma, smy, qr, qs, qm;
	logic [7:0] bm[3], bs[3], ba[3], br[3];
	logic [8:0] blend, hicut;
	int miscompares, tests_run, cyc;
	int sq[$];

	fap_demod_model u_src (.i_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_gap(gap),
		.i_mpx(mpx), .i_pilot(pilot), .o_vld(vld), .o_mpx(mpx_o), .o_pilot(pil_o));

	fap_audio_post dut (.I_CLK(clk), .I_RST_N(rst_n), .I_MPX_VLD(vld), .I_MPX(mpx_o),
		.I_PILOT(pil_o), .I_RSSI(rssi), .I_SNR(snr), .I_MULTIPATH(mp),
		.I_BL_RSSI_MONO(bm[0]), .I_BL_RSSI_STEREO(bs[0]), .I_BL_RSSI_ATTACK(ba[0]),
		.I_BL_RSSI_RELEASE(br[0]), .I_BL_SNR_MONO(bm[1]), .I_BL_SNR_STEREO(bs[1]),
		.I_BL_SNR_ATTACK(ba[1]), .I_BL_SNR_RELEASE(br[1]), .I_BL_MP_MONO(bm[2]),
		.I_BL_MP_STEREO(bs[2]), .I_BL_MP_ATTACK(ba[2]), .I_BL_MP_RELEASE(br[2]),
		.I_HC_SNR_MIN(hs0), .I_HC_SNR_MAX(hs1), .I_HC_MP_MIN(hm0), .I_HC_MP_MAX(hm1),
		.I_HC_SEL(hsel), .I_HC_ATTACK(hat), .I_HC_RELEASE(hrl),
		.I_DEEMPH_TIME_CONSTANT_PROP(de), .I_SM_SNR_THR(smt), .I_SM_DEPTH(smd),
		.I_SM_ATTACK(sma), .I_SM_DECAY(smy), .I_VOLUME(vol), .I_MUTE(mute),
		.O_LEFT_ANALOG_OUT(left), .O_RIGHT_ANALOG_OUT(right), .O_AUDIO_VLD(avld),
		.O_QSTAT_BLEND(blend), .O_QSTAT_HICUT(hicut), .O_QSTAT_SMUTE(smute),
		.O_QSTAT_RSSI(qr), .O_QSTAT_SNR(qs), .O_QSTAT_MP(qm));

	// clock generator
	always #12.5 clk = ~clk;

	function automatic logic near(input logic signed [15:0] a, input logic signed [15:0] b);
		int d;
		d = int'(a) - int'(b);
		return d >= -3 && d <= 3;
	endfunction : near

	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %0h seen %0h", n, e, s);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// run the source for n strobes, then let the pipeline drain
	task automatic send(input int n);
		int k;
		k = 0;
		run = 1'b1;
		while (k < n) begin
			@(posedge clk);
			if (vld) k++;
		end
		#1 run = 1'b0;
		tick(8);
		check("pending", sq.size(), 0);
	endtask : send

	task automatic settle();
		gap = 4'h0;
		send(300);
		gap = 4'h2;
	endtask : settle

	task automatic do_reset();
		rst_n = 1'b0;
		tick(16);
		rst_n = 1'b1;
	endtask : do_reset

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done

	// each output pulse must come four cycles after its strobe
	always @(posedge clk) begin
		cyc++;
		if (!rst_n) sq.delete();
		else begin
			if (vld) sq.push_back(cyc);
			if (avld) check("latency", (sq.size() > 0) ? cyc - sq.pop_front() : -1, 4);
		end
	end

	// watchdog against a hung pipeline
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done();
	end

	// main sequence
	initial begin
		clk = 1'b0; rst_n = 1'b0; run = 1'b0; gap = 4'h2; mpx = 16'sh1000; pilot = 16'sh0000;
		rssi = 8'hF0; snr = 8'hF0; mp = 8'h00; hs0 = 8'h30; hs1 = 8'h50; hm0 = 8'h20;
		hm1 = 8'h60; hsel = 3'h0; hat = 4'h0; hrl = 4'h1; de = 1'b0; smt = 8'h10;
		smd = 8'h80; sma = 8'hFF; smy = 8'hFF; vol = 6'h3F; mute = 1'b0;
		bm = '{8'h40, 8'h40, 8'hC0};
		bs = '{8'hC0, 8'hC0, 8'h10};
		ba = '{8'hFF, 8'hFF, 8'hFF};
		br = '{8'h10, 8'hFF, 8'hFF};
		do_reset();
		check("rst blend", blend, 9'h000);
		check("rst hicut", hicut, 9'h000);
		check("rst left", left, 16'h0000);
		send(4);
		check("blend ramp", blend, 9'h040);
		check("rssi stat", qr, 8'hF0);
		check("mp stat", qm, 8'h00);
		br[0] = 8'hFF;
		send(4);
		check("blend stereo", blend, 9'h100);
		rssi = 8'h80;
		send(4);
		check("blend mid", blend, 9'h080);
		snr = 8'h20;
		send(4);
		check("blend mono", blend, 9'h000);
		check("snr stat", qs, 8'h20);
		rssi = 8'hF0;
		snr = 8'hF0;
		$display("test blend done");
		rssi = 8'h05;
		send(4);
		check("smute rssi", smute, 1'b0);
		// mono reference from a clean filter state, both channels alike
		do_reset();
		settle();
		v0 = left;
		check("level", v0 > 16'sh0100, 1'b1);
		check("mono l eq r", right, left);
		vol = 6'h1F;
		settle();
		check("volume half", near(left, v0 / 2), 1'b1);
		vol = 6'h3F;
		mute = 1'b1;
		settle();
		check("mute left", left, 16'h0000);
		check("mute right", right, 16'h0000);
		mute = 1'b0;
		snr = 8'h0F;
		settle();
		check("smute flag", smute, 1'b1);
		check("smute depth", near(left, v0 / 2), 1'b1);
		snr = 8'hF0;
		$display("test gain done");
		pilot = 16'sh7FFF;
		rssi = 8'hF0;
		settle();
		check("stereo sep", left > right, 1'b1);
		check("sum kept", near((left + right) / 2, v0), 1'b1);
		rssi = 8'h10;
		settle();
		check("forced blend", blend, 9'h000);
		// filter history differs per channel, so compare from a clean start
		do_reset();
		settle();
		check("forced mono", right, left);
		pilot = 16'sh0000;
		$display("test decode done");
		do_reset();
		send(3);
		o50 = left;
		de = 1'b1;
		do_reset();
		send(3);
		o75 = left;
		check("deemph pos", o75 > 16'sh0000, 1'b1);
		check("deemph slower", o50 > o75, 1'b1);
		$display("test deemph done");
		// hi-cut attacks one step per tick and releases one step per two ticks
		hsel = 3'h3;
		run = 1'b1;
		snr = 8'h20;
		tick(4 * 312 + 150);
		check("hicut snr", hicut, 9'h004);
		snr = 8'hF0;
		mp = 8'h70;
		tick(4 * 312);
		check("hicut mp", hicut, 9'h008);
		mp = 8'h00;
		tick(2 * 624 + 100);
		check("hicut release", hicut == 9'h005 || hicut == 9'h006, 1'b1);
		run = 1'b0;
		tick(8);
		$display("test hicut done");
		test_done();
	end
endmodule : fap_audio_post_tb
`default_nettype wire
